// ### logic/arc_pkg.sv
package arc_pkg;
  // Register byte offsets on the plain register port
  localparam logic [7:0] ARC_OFS_MODE   = 8'h00;
  localparam logic [7:0] ARC_OFS_STATUS = 8'h04;
  localparam logic [7:0] ARC_OFS_MASK   = 8'h08;
  localparam logic [7:0] ARC_OFS_WOPEN  = 8'h0C;
  localparam logic [7:0] ARC_OFS_WCLOSE = 8'h10;
  localparam logic [7:0] ARC_OFS_PPOS   = 8'h14;
  localparam logic [7:0] ARC_OFS_SPOS   = 8'h18;
  localparam logic [7:0] ARC_OFS_AXIS   = 8'h1C;

  // Mode word layout
  localparam int ARC_MODE_W   = 11;
  localparam int ARC_PSRC_LSB = 0;
  localparam int ARC_PEN_BIT  = 2;
  localparam int ARC_PEDG_BIT = 3;
  localparam int ARC_SSRC_LSB = 4;
  localparam int ARC_SEN_BIT  = 6;
  localparam int ARC_SEDG_BIT = 7;
  localparam int ARC_WIN_LSB  = 8;
  localparam int ARC_FILT_BIT = 10;

  // Axis configuration layout
  localparam int ARC_AXIS_TYPE_CODE_W  = 8;
  localparam int ARC_NET_BIT  = 8;

  // Registration source and windowing codes
  localparam logic [1:0] ARC_SRC_MARKER = 2'h0;
  localparam logic [1:0] ARC_SRC_IN0    = 2'h1;
  localparam logic [1:0] ARC_SRC_IN1    = 2'h2;
  localparam logic [1:0] ARC_WIN_NONE   = 2'h0;
  localparam logic [1:0] ARC_WIN_EXCL   = 2'h3;

  // Axis types that own a secondary capture (43, 44, 45)
  localparam logic [7:0] ARC_AXIS_TYPE_CODE_SEC0 = 8'h2B;
  localparam logic [7:0] ARC_AXIS_TYPE_CODE_SEC1 = 8'h2C;
  localparam logic [7:0] ARC_AXIS_TYPE_CODE_SEC2 = 8'h2D;

  // Reset values
  localparam logic [10:0] ARC_MODE_RST  = 11'h000;
  localparam logic [1:0]  ARC_MASK_RST  = 2'h0;
  localparam logic [7:0]  ARC_AXIS_TYPE_CODE_RST = 8'h00;

  // Filter time and derived clock count, 50 MHz core clock
  localparam int ARC_CLK_NS      = 20;
  localparam int ARC_FILT_NS     = 200;
  localparam int ARC_FILT_CYC    = (ARC_FILT_NS + ARC_CLK_NS - 1)
                                   / ARC_CLK_NS;
endpackage : arc_pkg

// ### logic/arc_edge_sel.sv
`timescale 1ns/10ps
module arc_edge_sel
  import arc_pkg::*;
#(
  parameter int FILT_CYC = ARC_FILT_CYC
) (
  input  wire logic core_clk,
  input  wire logic rst_b,
  input  wire logic sig,
  input  wire logic filt_en,
  input  wire logic falling,
  input  wire logic resync,
  output logic      evt
);
  localparam int CW = $clog2(FILT_CYC) + 1;
  localparam logic [CW-1:0] LAST = CW'(FILT_CYC - 1);

  logic          lvl_reg;
  logic [CW-1:0] cnt_reg;
  logic          flip;

  // Level change taken at once, or after FILT_CYC stable cycles
  assign flip = (sig != lvl_reg) && (!filt_en || cnt_reg == LAST);
  // Same-cycle pulse so the caller latches position at the edge
  assign evt  = flip && !resync && (sig == !falling);

  // Tracked level; resync adopts a newly selected source silently
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lvl_reg <= 1'b0;
    end else if (resync || flip) begin
      lvl_reg <= sig;
    end
  end

  // Stability counter, restarts on any glitch back
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= '0;
    end else if (resync || sig == lvl_reg || flip) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + CW'(1);
    end
  end
endmodule : arc_edge_sel

// ### logic/axis_registration_capture.sv
// Contract
// - Primary event sets primary flag and latches position into primary value.
// - Secondary event sets its flag and value; only axis types 43-45.
// - Encoder axes of types 43-45 get two independent captures, each with its own input.
// - Network axes have one capture; source marker or drive inputs one-three.
// - Encoder axes latch position in hardware in the cycle of the edge.
// - Inclusive window accepts only strictly between open and close.
// - Exclusive window accepts only outside the open-close range.
// - Mode bits 1:0 primary source, bit 2 enable, bit 3 edge.
// - Mode bits 5:4 secondary source, bit 6 enable, bit 7 edge.
// - Mode bits 9:8: 00 none, 01/10 inclusive, 11 exclusive windowing.
// - Mode bit 10 enables registration input filtering on encoder axes.
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
module axis_registration_capture
  import arc_pkg::*;
#(
  parameter int FILT_CYC = ARC_FILT_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             irq,
  input  wire logic        enc_marker,
  input  wire logic        reg_in0,
  input  wire logic        reg_in1,
  input  wire logic [31:0] axis_position,
  input  wire logic        drive_cap_valid,
  input  wire logic [31:0] drive_cap_position,
  output logic      [1:0]  drive_capture_select,
  output logic             drive_capture_armed
);
  logic [ARC_MODE_W-1:0]  mode_reg;
  logic [1:0]             status_reg;
  logic [1:0]             mask_reg;
  logic signed [31:0]     wopen_reg;
  logic signed [31:0]     wclose_reg;
  logic [31:0]            ppos_reg;
  logic [31:0]            spos_reg;
  logic [ARC_AXIS_TYPE_CODE_W-1:0] axis_type_code_reg;
  logic                   net_reg;
  logic                   parm_reg;
  logic                   sarm_reg;
  logic                   setup_d_reg;
  logic [31:0]            rdata_next;
  logic                   setup_wr;
  logic                   sec_ok;
  logic                   psig;
  logic                   ssig;
  logic                   p_evt;
  logic                   s_evt;
  logic                   win_enc;
  logic                   win_drv;
  logic                   p_acc;
  logic                   s_acc;
  logic [1:0]             w1c;

  // Registration source decode, shared by both captures
  function automatic logic src_mux(input logic [1:0] sel,
                                   input logic mk, input logic i0,
                                   input logic i1);
    unique case (sel)
      ARC_SRC_MARKER: src_mux = mk;
      ARC_SRC_IN0:    src_mux = i0;
      ARC_SRC_IN1:    src_mux = i1;
      default:        src_mux = 1'b0;
    endcase
  endfunction : src_mux

  // Window test; the two inclusive codes behave alike
  function automatic logic win_ok(input logic [1:0] w,
                                  input logic signed [31:0] p,
                                  input logic signed [31:0] o,
                                  input logic signed [31:0] c);
    if (w == ARC_WIN_NONE) begin
      win_ok = 1'b1;
    end else if (w == ARC_WIN_EXCL) begin
      win_ok = (p < o) || (p > c);
    end else begin
      win_ok = (p > o) && (p < c);
    end
  endfunction : win_ok

  // Setup strobe and axis capability
  assign setup_wr = reg_wr && (reg_addr == ARC_OFS_MODE);
  assign sec_ok   = !net_reg && (axis_type_code_reg == ARC_AXIS_TYPE_CODE_SEC0 ||
                    axis_type_code_reg == ARC_AXIS_TYPE_CODE_SEC1 ||
                    axis_type_code_reg == ARC_AXIS_TYPE_CODE_SEC2);
  assign w1c      = (reg_wr && reg_addr == ARC_OFS_STATUS) ?
                    reg_wdata[1:0] : 2'h0;

  // Source selection per capture, each its own input path
  assign psig = src_mux(mode_reg[ARC_PSRC_LSB +: 2], enc_marker,
                        reg_in0, reg_in1);
  assign ssig = src_mux(mode_reg[ARC_SSRC_LSB +: 2], enc_marker,
                        reg_in0, reg_in1);

  // Edge and filter stages; resync hides the source switch on setup
  arc_edge_sel #(.FILT_CYC(FILT_CYC)) u_prim (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .sig      (psig),
    .filt_en  (mode_reg[ARC_FILT_BIT]),
    .falling  (mode_reg[ARC_PEDG_BIT]),
    .resync   (setup_d_reg),
    .evt      (p_evt)
  );
  arc_edge_sel #(.FILT_CYC(FILT_CYC)) u_sec (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .sig      (ssig),
    .filt_en  (mode_reg[ARC_FILT_BIT]),
    .falling  (mode_reg[ARC_SEDG_BIT]),
    .resync   (setup_d_reg),
    .evt      (s_evt)
  );

  // Window gating on live position or on the drive's own latch
  assign win_enc = win_ok(mode_reg[ARC_WIN_LSB +: 2], axis_position,
                          wopen_reg, wclose_reg);
  assign win_drv = win_ok(mode_reg[ARC_WIN_LSB +: 2],
                          drive_cap_position,
                          wopen_reg, wclose_reg);

  // Accepted events; a setup in the same cycle takes priority
  assign p_acc = !setup_wr && parm_reg &&
                 (net_reg ? (drive_cap_valid && win_drv)
                          : (p_evt && win_enc));
  assign s_acc = !setup_wr && !net_reg && sarm_reg && s_evt &&
                 win_enc;

  // Mode register doubles as the setup command
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg <= ARC_MODE_RST;
    end else if (setup_wr) begin
      mode_reg <= reg_wdata[ARC_MODE_W-1:0];
    end
  end

  // Delayed setup drives the edge stages' resync
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      setup_d_reg <= 1'b0;
    end else begin
      setup_d_reg <= setup_wr;
    end
  end

  // Arming: one shot per setup, so a value holds until re-armed
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      parm_reg <= 1'b0;
      sarm_reg <= 1'b0;
    end else if (setup_wr) begin
      parm_reg <= net_reg || reg_wdata[ARC_PEN_BIT];
      sarm_reg <= sec_ok && reg_wdata[ARC_SEN_BIT];
    end else begin
      if (p_acc) begin
        parm_reg <= 1'b0;
      end
      if (s_acc) begin
        sarm_reg <= 1'b0;
      end
    end
  end

  // Capture flags: setup clears, capture beats write-one-to-clear
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_reg <= 2'h0;
    end else if (setup_wr) begin
      status_reg <= 2'h0;
    end else begin
      status_reg <= (status_reg & ~w1c) | {s_acc, p_acc};
    end
  end

  // Position latches, taken in the very cycle of the edge
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ppos_reg <= 32'h0000_0000;
      spos_reg <= 32'h0000_0000;
    end else begin
      if (p_acc) begin
        ppos_reg <= net_reg ? drive_cap_position
                            : axis_position;
      end
      if (s_acc) begin
        spos_reg <= axis_position;
      end
    end
  end

  // Software settings: mask, window bounds, axis configuration
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mask_reg   <= ARC_MASK_RST;
      wopen_reg  <= 32'sh0000_0000;
      wclose_reg <= 32'sh0000_0000;
      axis_type_code_reg  <= ARC_AXIS_TYPE_CODE_RST;
      net_reg    <= 1'b0;
    end else if (reg_wr) begin
      unique case (reg_addr)
        ARC_OFS_MASK:   mask_reg   <= reg_wdata[1:0];
        ARC_OFS_WOPEN:  wopen_reg  <= reg_wdata;
        ARC_OFS_WCLOSE: wclose_reg <= reg_wdata;
        ARC_OFS_AXIS: begin
          axis_type_code_reg <= reg_wdata[ARC_AXIS_TYPE_CODE_W-1:0];
          net_reg   <= reg_wdata[ARC_NET_BIT];
        end
        default: ;
      endcase
    end
  end

  // Read decode; unmapped addresses read zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (reg_addr)
      ARC_OFS_MODE:   rdata_next[ARC_MODE_W-1:0] = mode_reg;
      ARC_OFS_STATUS: rdata_next[1:0] = status_reg;
      ARC_OFS_MASK:   rdata_next[1:0] = mask_reg;
      ARC_OFS_WOPEN:  rdata_next = wopen_reg;
      ARC_OFS_WCLOSE: rdata_next = wclose_reg;
      ARC_OFS_PPOS:   rdata_next = ppos_reg;
      ARC_OFS_SPOS:   rdata_next = spos_reg;
      ARC_OFS_AXIS: begin
        rdata_next[ARC_AXIS_TYPE_CODE_W-1:0] = axis_type_code_reg;
        rdata_next[ARC_NET_BIT]     = net_reg;
      end
      default: ;
    endcase
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_rd ? rdata_next : 32'h0000_0000;
    end
  end

  // Interrupt level lags status by one cycle, flop-driven output
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_reg & mask_reg);
    end
  end

  // Drive-facing outputs: selected source and armed state
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      drive_capture_select <= ARC_SRC_MARKER;
      drive_capture_armed  <= 1'b0;
    end else begin
      drive_capture_select <= mode_reg[ARC_PSRC_LSB +: 2];
      drive_capture_armed  <= parm_reg && net_reg;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence s_setup;
    setup_wr;
  endsequence
  // Resync cycle: encoder stages quiet, drive reports still pass
  sequence s_cleared;
    status_reg == 2'h0 && !s_acc && (net_reg || !p_acc);
  endsequence

  property p_prim_cap;
    (!net_reg && p_acc) |=> status_reg[0] &&
      ppos_reg == $past(axis_position);
  endproperty
  a_prim_cap: assert property (p_prim_cap)
    else $error("primary capture missed");
  property p_sec_cap;
    s_acc |=> status_reg[1] && spos_reg == $past(axis_position);
  endproperty
  a_sec_cap: assert property (p_sec_cap)
    else $error("secondary capture missed");
  property p_sec_type;
    (!status_reg[1] ##1 status_reg[1]) |-> $past(sarm_reg) &&
      ($past(axis_type_code_reg) inside {8'h2B, 8'h2C, 8'h2D});
  endproperty
  a_sec_type: assert property (p_sec_type)
    else $error("secondary flag on wrong axis type");
  property p_net_single;
    (net_reg && $past(net_reg) && !setup_wr) |-> !s_acc &&
      (p_acc == (parm_reg && drive_cap_valid && win_drv));
  endproperty
  a_net_single: assert property (p_net_single)
    else $error("network axis capture misbehaves");
  property p_drv_sel;
    ##1 drive_capture_select == $past(mode_reg[1:0]);
  endproperty
  a_drv_sel: assert property (p_drv_sel)
    else $error("drive source select wrong");
  property p_win_incl;
    (p_acc && !net_reg && (mode_reg[9:8] == 2'h1 ||
      mode_reg[9:8] == 2'h2)) |-> $signed(axis_position) > wopen_reg &&
      $signed(axis_position) < wclose_reg;
  endproperty
  a_win_incl: assert property (p_win_incl)
    else $error("inclusive window violated");
  property p_win_excl;
    (((p_acc && !net_reg) || s_acc) && mode_reg[9:8] == 2'h3) |->
      ($signed(axis_position) < wopen_reg ||
      $signed(axis_position) > wclose_reg);
  endproperty
  a_win_excl: assert property (p_win_excl)
    else $error("exclusive window violated");
  property p_setup;
    s_setup |=> s_cleared ##1 ($past(net_reg) || status_reg == 2'h0);
  endproperty
  a_setup: assert property (p_setup)
    else $error("setup did not clear and resync");
  property p_hold;
    !p_acc |=> $stable(ppos_reg);
  endproperty
  a_hold: assert property (p_hold)
    else $error("primary position changed without capture");
  property p_filter;
    (p_evt && mode_reg[ARC_FILT_BIT] && !net_reg) |-> psig == $past(psig)
      && (FILT_CYC < 3 || psig == $past(psig, 2));
  endproperty
  a_filter: assert property (p_filter)
    else $error("filtered event without a stable input");
endmodule : axis_registration_capture

// ### tb/arc_drive_model.sv
`timescale 1ns/10ps
module arc_drive_model #(
  parameter logic [15:0] ALLOC = 16'hD540,
  parameter int          LAT   = 3
) (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        enc_marker,
  input  wire logic [2:0]  ext_in,
  input  wire logic [31:0] axis_position,
  input  wire logic [1:0]  drive_capture_select,
  input  wire logic        drive_capture_armed,
  output logic             drive_cap_valid,
  output logic      [31:0] drive_cap_position
);
  logic [3:0]  code;
  logic        lvl;
  logic        lvl_q;
  logic [1:0]  sel_q;
  logic [31:0] lat_pos;
  int          cnt;

  // Source level from one digit of the allocation word; select 0 takes the marker
  always_comb begin
    code = ALLOC[4*drive_capture_select +: 4];
    case (code)
      4'h4, 4'h5, 4'h6: lvl = ext_in[2'(code - 4'h4)];
      4'hD, 4'hE, 4'hF: lvl = ~ext_in[2'(code - 4'hD)];
      4'h8:             lvl = 1'b1;
      default:          lvl = 1'b0;
    endcase
    if (drive_capture_select == 2'h0) begin
      lvl = enc_marker;
    end
  end

  // Latch on the drive's own edge, report later; a select change is
  // not an edge, and a stale position is never held on the bus
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lvl_q              <= 1'b0;
      sel_q              <= 2'h0;
      cnt                <= 0;
      lat_pos            <= 32'h0;
      drive_cap_valid    <= 1'b0;
      drive_cap_position <= 32'h0;
    end else begin
      lvl_q              <= lvl;
      sel_q              <= drive_capture_select;
      if (cnt == 1) begin
        drive_cap_valid    <= 1'b1;
        drive_cap_position <= lat_pos;
      end else begin
        drive_cap_valid    <= 1'b0;
        drive_cap_position <= ~drive_cap_position;
      end
      if (cnt > 0) begin
        cnt <= cnt - 1;
      end else if (drive_capture_armed && lvl && !lvl_q
                   && sel_q == drive_capture_select) begin
        lat_pos <= axis_position;
        cnt     <= LAT;
      end
    end
  end
endmodule : arc_drive_model

// ### tb/axis_registration_capture_test.sv
`timescale 1ns/10ps
module axis_registration_capture_test;
  import arc_pkg::*;
  localparam int FILT = 3;
  logic        core_clk, rst_b, reg_wr, reg_rd, irq;
  logic        enc_marker, reg_in0, reg_in1, fall;
  logic        drive_cap_valid, drive_capture_armed;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, axis_position, drive_cap_position;
  logic [1:0]  drive_capture_select;
  logic [2:0]  ext_in;
  int          errors, n_tests, cycles, src;

  axis_registration_capture #(.FILT_CYC(FILT)) i_axis_registration_capture (
    .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .enc_marker(enc_marker),
    .reg_in0(reg_in0), .reg_in1(reg_in1), .axis_position(axis_position),
    .drive_cap_valid(drive_cap_valid),
    .drive_cap_position(drive_cap_position),
    .drive_capture_select(drive_capture_select),
    .drive_capture_armed(drive_capture_armed));

  arc_drive_model i_arc_drive_model (
    .core_clk(core_clk), .rst_b(rst_b), .enc_marker(enc_marker),
    .ext_in(ext_in), .axis_position(axis_position),
    .drive_capture_select(drive_capture_select),
    .drive_capture_armed(drive_capture_armed),
    .drive_cap_valid(drive_cap_valid),
    .drive_cap_position(drive_cap_position));

  // 50 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Hang guard, well above the run length
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      test_done();
    end
  end

  task automatic test_done;
    $display("Checks %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t: word %h not %h", $time, got, exp);
    end
  endtask : chk_word

  // Pin is copied on entry, so the caller settles past the edge first
  task automatic chk_pin(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t: pin %b not %b", $time, got, exp);
    end
  endtask : chk_pin

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk_word(reg_rdata, exp);
  endtask : rd

  // Setup plus a spare cycle, so events land after the resync cycle
  task automatic setup(input logic [10:0] m);
    wr(ARC_OFS_MODE, {21'h0, m});
    @(posedge core_clk);
  endtask : setup

  // One level change on a source; position moves on right after it
  task automatic ev(input int s, input logic lv, input logic [31:0] p);
    @(posedge core_clk);
    axis_position <= p;
    case (s)
      0:       enc_marker <= lv;
      1:       reg_in0 <= lv;
      2:       reg_in1 <= lv;
      default: ext_in[s-3] <= lv;
    endcase
    @(posedge core_clk);
    axis_position <= ~p;
    repeat (8) @(posedge core_clk);
  endtask : ev

  task automatic wtry(input logic [1:0] w, input logic [31:0] p,
                      input logic hit);
    setup({1'b0, w, 8'h05});
    ev(1, 1'b1, p);
    rd(ARC_OFS_STATUS, {31'h0, hit});
    if (hit) rd(ARC_OFS_PPOS, p);
    ev(1, 1'b0, p);
  endtask : wtry

  initial begin
    {reg_wr, reg_rd, enc_marker, reg_in0, reg_in1} = 5'h00;
    reg_addr      = 8'h00;
    reg_wdata     = 32'h0;
    axis_position = 32'h0;
    ext_in        = 3'h0;
    rst_b         = 1'b0;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    // Reset values and an unmapped address
    rd(ARC_OFS_MODE, {21'h0, ARC_MODE_RST});
    rd(ARC_OFS_MASK, {30'h0, ARC_MASK_RST});
    rd(ARC_OFS_AXIS, {24'h0, ARC_AXIS_TYPE_CODE_RST});
    rd(ARC_OFS_STATUS, 32'h0);
    rd(8'h20, 32'h0);
    // Primary capture, refusal of a second event, mask and clear
    wr(ARC_OFS_MASK, 32'h1);
    setup(11'h005);
    ev(1, 1'b1, 32'h1234);
    rd(ARC_OFS_STATUS, 32'h1);
    rd(ARC_OFS_PPOS, 32'h1234);
    @(posedge core_clk);
    #1;
    chk_word(reg_rdata, 32'h0);
    chk_pin(irq, 1'b1);
    ev(1, 1'b0, 32'h0);
    ev(1, 1'b1, 32'h5555);
    wr(ARC_OFS_PPOS, 32'hFFFF);
    rd(ARC_OFS_PPOS, 32'h1234);
    wr(ARC_OFS_MASK, 32'h2);
    repeat (2) @(posedge core_clk);
    #1;
    chk_pin(irq, 1'b0);
    wr(ARC_OFS_MASK, 32'h1);
    repeat (2) @(posedge core_clk);
    #1;
    chk_pin(irq, 1'b1);
    wr(ARC_OFS_STATUS, 32'h1);
    repeat (2) @(posedge core_clk);
    #1;
    chk_pin(irq, 1'b0);
    ev(1, 1'b0, 32'h0);
    wr(ARC_OFS_STATUS, 32'h0);
    setup(11'h005);
    rd(ARC_OFS_PPOS, 32'h1234);
    // Every primary source on both edges, other input ignored
    for (int i = 0; i < 6; i++) begin
      src  = i % 3;
      fall = (i >= 3);
      ev(src, fall, 32'h0);
      ev((src + 1) % 3, fall, 32'h0);
      setup({7'h0, fall, 1'b1, 2'(src)});
      rd(ARC_OFS_STATUS, 32'h0);
      ev((src + 1) % 3, ~fall, 32'h77);
      rd(ARC_OFS_STATUS, 32'h0);
      ev(src, ~fall, 32'h100 + i);
      rd(ARC_OFS_STATUS, 32'h1);
      rd(ARC_OFS_PPOS, 32'h100 + i);
      ev(src, 1'b0, 32'h0);
      ev((src + 1) % 3, 1'b0, 32'h0);
    end
    // Filter rejects a pulse one cycle short, takes a long one
    setup(11'h405);
    @(posedge core_clk);
    reg_in0 <= 1'b1;
    repeat (FILT - 1) @(posedge core_clk);
    reg_in0 <= 1'b0;
    repeat (6) @(posedge core_clk);
    rd(ARC_OFS_STATUS, 32'h0);
    @(posedge core_clk);
    reg_in0       <= 1'b1;
    axis_position <= 32'h400;
    repeat (FILT + 4) @(posedge core_clk);
    rd(ARC_OFS_STATUS, 32'h1);
    rd(ARC_OFS_PPOS, 32'h400);
    ev(1, 1'b0, 32'h0);
    // Secondary capture only on axis types 43 to 45
    for (int t = 0; t < 4; t++) begin
      wr(ARC_OFS_AXIS, 32'h2A + t);
      ev(2, 1'b1, 32'h0);
      setup(11'h0E5);
      ev(2, 1'b0, 32'h200 + t);
      rd(ARC_OFS_STATUS, {30'h0, t != 0, 1'b0});
      ev(1, 1'b1, 32'h300 + t);
      rd(ARC_OFS_STATUS, {30'h0, t != 0, 1'b1});
      rd(ARC_OFS_PPOS, 32'h300 + t);
      if (t != 0) rd(ARC_OFS_SPOS, 32'h200 + t);
      ev(1, 1'b0, 32'h0);
    end
    // Window boundaries, signed positions included
    wr(ARC_OFS_AXIS, 32'h0);
    wr(ARC_OFS_WOPEN, 32'd100);
    wr(ARC_OFS_WCLOSE, 32'd200);
    wtry(2'h1, 32'd100, 1'b0);
    wtry(2'h1, 32'd200, 1'b0);
    wtry(2'h2, 32'd101, 1'b1);
    wtry(2'h3, 32'd150, 1'b0);
    wtry(2'h3, 32'd100, 1'b0);
    wtry(2'h3, 32'hFFFF_FFFB, 1'b1);
    wtry(2'h3, 32'd201, 1'b1);
    wtry(2'h0, 32'd100, 1'b1);
    // Network axis: one capture, drive latches from each source
    wr(ARC_OFS_AXIS, 32'h100);
    for (int s = 0; s < 4; s++) begin
      @(posedge core_clk);
      enc_marker <= 1'b0;
      ext_in     <= (s == 3) ? 3'h1 : 3'h0;
      setup({9'h0, 2'(s)});
      #1;
      chk_pin(drive_capture_armed, 1'b1);
      chk_word({30'h0, drive_capture_select}, 32'(s));
      ev(s == 0 ? 0 : (s == 3 ? 3 : s + 2), s != 3, 32'h500 + s);
      rd(ARC_OFS_STATUS, 32'h1);
      rd(ARC_OFS_PPOS, 32'h500 + s);
    end
    test_done();
  end
endmodule : axis_registration_capture_test
